// >>> hdl/timer_ctl_pkg.sv
// constants, register layouts and encodings of the timer capture and output control
package timer_ctl_pkg;

   localparam int          COUNT_W        = 16;
   localparam logic [15:0] ADDR_MODE      = 16'hFF60;
   localparam logic [15:0] ADDR_PRESCALER = 16'hFF61;
   localparam logic [15:0] ADDR_CAPCMP    = 16'hFF62;
   localparam logic [15:0] ADDR_OUTPUT    = 16'hFF63;
   localparam logic [7:0]  RESET_BYTE     = 8'h00;
   localparam logic [7:0]  READ_NONE      = 8'h00;

   // prescaler divide ratios, the divider that serves them, and counter values
   localparam int          DIV_W          = 8;
   localparam logic [7:0]  DIV4_LAST      = 8'h03;
   localparam logic [7:0]  DIV256_LAST    = 8'hFF;
   localparam logic [7:0]  DIV_ZERO       = 8'h00;
   localparam logic [15:0] COUNT_ZERO     = 16'h0000;
   localparam logic [15:0] COUNT_ONE      = 16'h0001;
   localparam logic [15:0] COUNT_MAX      = 16'hFFFF;

   // valid edge encodings; 2'b10 is not allowed and detects nothing
   localparam logic [1:0]  EDGE_FALL      = 2'h0;
   localparam logic [1:0]  EDGE_RISE      = 2'h1;
   localparam logic [1:0]  EDGE_BOTH      = 2'h3;

   localparam logic [1:0]  CLK_FULL       = 2'h0;
   localparam logic [1:0]  CLK_DIV4       = 2'h1;
   localparam logic [1:0]  CLK_DIV256     = 2'h2;
   localparam logic [1:0]  CLK_EXTERNAL   = 2'h3;

   localparam logic [1:0]  MODE_STOP      = 2'h0;
   localparam logic [1:0]  MODE_FREE      = 2'h1;
   localparam logic [1:0]  MODE_CLR_EDGE  = 2'h2;
   localparam logic [1:0]  MODE_CLR_MATCH = 2'h3;

   // {level set, level reset}
   localparam logic [1:0]  LEVEL_RESET    = 2'h1;
   localparam logic [1:0]  LEVEL_SET      = 2'h2;

   typedef struct packed {
      logic [3:0] zero;
      logic [1:0] mode;            // {mode_bit_high, mode_bit_low}
      logic       invert_on_edge;
      logic       unused_flag;
   } timer_mode_control_t;

   typedef struct packed {
      logic [1:0] second_edge;     // {second_input_edge_hi, second_input_edge_lo}
      logic [1:0] first_edge;      // {first_input_edge_hi, first_input_edge_lo}
      logic [1:0] zero;
      logic [1:0] clock_sel;       // {count_clock_sel_hi, count_clock_sel_lo}
   } prescaler_edge_select_t;

   typedef struct packed {
      logic [4:0] zero;
      logic       second_reg_capture_mode;
      logic       first_reg_trigger_select;
      logic       first_reg_capture_mode;
   } capture_compare_control_t;

   typedef struct packed {
      logic zero;
      logic oneshot_soft_trigger;
      logic oneshot_mode_enable;
      logic invert_on_second_match;
      logic output_level_set;
      logic output_level_reset;
      logic invert_on_first_match;
      logic output_enable_bit;
   } timer_output_control_t;

endpackage : timer_ctl_pkg

// >>> hdl/edge_filter.sv
// sampled two-times noise filter and valid edge detector for one timer input
`timescale 1ns/1ps
module edge_filter (
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   input  wire logic       run_i,
   input  wire logic       sample_i,
   input  wire logic       level_i,
   input  wire logic [1:0] edge_sel_i,
   output logic            valid_o,
   output logic            opposite_o
);

   logic prev_sample;
   logic state;
   logic rise;
   logic fall;

   // the level counts only when two successive samples agree
   assign rise = run_i && sample_i && prev_sample && level_i && !state;
   assign fall = run_i && sample_i && !prev_sample && !level_i && state;

   // state freezes while stopped, so a level changed meanwhile shows as an edge at restart
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         prev_sample <= 1'b0;
         state       <= 1'b0;
      end else if (run_i && sample_i) begin
         prev_sample <= level_i;
         if (rise || fall) begin
            state <= level_i;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         valid_o    <= 1'b0;
         opposite_o <= 1'b0;
      end else begin
         valid_o    <= (rise && (edge_sel_i == timer_ctl_pkg::EDGE_RISE
                                 || edge_sel_i == timer_ctl_pkg::EDGE_BOTH))
                    || (fall && (edge_sel_i == timer_ctl_pkg::EDGE_FALL
                                 || edge_sel_i == timer_ctl_pkg::EDGE_BOTH));
         // with both edges valid there is no opposite phase at all
         opposite_o <= (rise && edge_sel_i == timer_ctl_pkg::EDGE_FALL)
                    || (fall && edge_sel_i == timer_ctl_pkg::EDGE_RISE);
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   property p_filter_twice;
      valid_o |-> $past(level_i) == $past(level_i, 2) && $past(sample_i);
   endproperty
   a_filter_twice: assert property (p_filter_twice)
      else $error("edge reported without two agreeing samples");

   property p_no_edge_stopped;
      !run_i |=> !valid_o && !opposite_o;
   endproperty
   a_no_edge_stopped: assert property (p_no_edge_stopped)
      else $error("edge reported while timer stopped");

endmodule : edge_filter

// >>> hdl/timer_capture_output_control.sv
// capture/compare mode, prescaler, edge selection and timer output flip-flop control
`timescale 1ns/1ps
module timer_capture_output_control #(
   parameter int CNT_W = timer_ctl_pkg::COUNT_W
) (
   input  wire logic             CLK_I,
   input  wire logic             RESET_I,
   input  wire logic [15:0]      ADDR_I,
   input  wire logic [7:0]       WDATA_I,
   input  wire logic             WR_I,
   input  wire logic             RD_I,
   input  wire logic             FIRST_TIMER_INPUT_I,
   input  wire logic             SECOND_TIMER_INPUT_I,
   input  wire logic [CNT_W-1:0] FIRST_COMPARE_I,
   input  wire logic [CNT_W-1:0] SECOND_COMPARE_I,
   output logic [7:0]            RDATA_O,
   output logic                  TIMER_OUTPUT_PIN_O,
   output logic [CNT_W-1:0]      COUNT_O,
   output logic [CNT_W-1:0]      FIRST_CAPTURE_O,
   output logic [CNT_W-1:0]      SECOND_CAPTURE_O,
   output logic                  FIRST_MATCH_O,
   output logic                  SECOND_MATCH_O,
   output logic                  OVERFLOW_O
);

   timer_ctl_pkg::timer_mode_control_t      timer_mode_control;
   timer_ctl_pkg::prescaler_edge_select_t   prescaler_edge_select;
   timer_ctl_pkg::capture_compare_control_t capture_compare_control;
   timer_ctl_pkg::timer_output_control_t    timer_output_control;
   timer_ctl_pkg::timer_output_control_t    toc_wr;

   logic [1:0]                  first_sync;
   logic [1:0]                  second_sync;
   logic [timer_ctl_pkg::DIV_W-1:0] div_cnt;
   logic                        run;
   logic                        count_tick;
   logic                        capture_sample;
   logic                        ext_edge;
   logic                        first_edge;
   logic                        first_opposite;
   logic                        second_edge;
   logic                        match_first;
   logic                        match_second;
   logic                        trig_first;
   logic                        trig_second;
   logic                        wr_toc;
   logic                        soft_trigger;
   logic                        oneshot_ok;
   logic                        armed;
   logic                        out_ff;
   logic                        next_out_ff;
   logic                        next_enable;
   logic                        flip;

   assign toc_wr = timer_ctl_pkg::timer_output_control_t'(WDATA_I);
   assign wr_toc = WR_I && ADDR_I == timer_ctl_pkg::ADDR_OUTPUT;
   assign run    = timer_mode_control.mode != timer_ctl_pkg::MODE_STOP;

   // register writes; fixed-zero fields never store anything
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         timer_mode_control      <= timer_ctl_pkg::RESET_BYTE;
         prescaler_edge_select   <= timer_ctl_pkg::RESET_BYTE;
         capture_compare_control <= timer_ctl_pkg::RESET_BYTE;
         timer_output_control    <= timer_ctl_pkg::RESET_BYTE;
      end else if (WR_I) begin
         if (ADDR_I == timer_ctl_pkg::ADDR_MODE) begin
            timer_mode_control      <= {4'h0, WDATA_I[3:1], 1'b0};
         end else if (ADDR_I == timer_ctl_pkg::ADDR_PRESCALER) begin
            prescaler_edge_select   <= {WDATA_I[7:4], 2'h0, WDATA_I[1:0]};
         end else if (ADDR_I == timer_ctl_pkg::ADDR_CAPCMP) begin
            capture_compare_control <= {5'h00, WDATA_I[2:0]};
         end else if (ADDR_I == timer_ctl_pkg::ADDR_OUTPUT) begin
            // trigger and level bits act once and are never stored
            timer_output_control    <= {2'h0, WDATA_I[5:4], 2'h0, WDATA_I[1:0]};
         end
      end
   end

   // read data one cycle after the strobe; unmapped addresses read zero
   always_ff @(posedge CLK_I) begin
      if (RESET_I || !RD_I) begin
         RDATA_O <= timer_ctl_pkg::READ_NONE;
      end else if (ADDR_I == timer_ctl_pkg::ADDR_MODE) begin
         RDATA_O <= timer_mode_control;
      end else if (ADDR_I == timer_ctl_pkg::ADDR_PRESCALER) begin
         RDATA_O <= prescaler_edge_select;
      end else if (ADDR_I == timer_ctl_pkg::ADDR_CAPCMP) begin
         RDATA_O <= capture_compare_control;
      end else if (ADDR_I == timer_ctl_pkg::ADDR_OUTPUT) begin
         RDATA_O <= timer_output_control;
      end else begin
         RDATA_O <= timer_ctl_pkg::READ_NONE;
      end
   end

   // pins come from outside the clock domain
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         first_sync  <= 2'h0;
         second_sync <= 2'h0;
      end else begin
         first_sync  <= {first_sync[0], FIRST_TIMER_INPUT_I};
         second_sync <= {second_sync[0], SECOND_TIMER_INPUT_I};
      end
   end

   // prescaler divider, held at zero while stopped so ticks start aligned
   always_ff @(posedge CLK_I) begin
      if (RESET_I || !run) begin
         div_cnt <= timer_ctl_pkg::DIV_ZERO;
      end else begin
         div_cnt <= div_cnt + 8'h01;
      end
   end

   always_comb begin
      case (prescaler_edge_select.clock_sel)
         timer_ctl_pkg::CLK_FULL:   count_tick = run;
         timer_ctl_pkg::CLK_DIV4:   count_tick = run && div_cnt[1:0] == timer_ctl_pkg::DIV4_LAST[1:0];
         timer_ctl_pkg::CLK_DIV256: count_tick = run && div_cnt == timer_ctl_pkg::DIV256_LAST;
         default:                   count_tick = run && ext_edge;
      endcase
   end

   // capture inputs are sampled at the count clock; an external count clock samples at fxp
   assign capture_sample = prescaler_edge_select.clock_sel == timer_ctl_pkg::CLK_EXTERNAL
                           || count_tick;

   // first pin as count clock, sampled every fxp cycle
   edge_filter u_count_edge (
      .clk_i      (CLK_I),
      .reset_i    (RESET_I),
      .run_i      (run),
      .sample_i   (1'b1),
      .level_i    (first_sync[1]),
      .edge_sel_i (prescaler_edge_select.first_edge),
      .valid_o    (ext_edge),
      .opposite_o ()
   );

   // first pin as capture or clear trigger
   edge_filter u_first_edge (
      .clk_i      (CLK_I),
      .reset_i    (RESET_I),
      .run_i      (run),
      .sample_i   (capture_sample),
      .level_i    (first_sync[1]),
      .edge_sel_i (prescaler_edge_select.first_edge),
      .valid_o    (first_edge),
      .opposite_o (first_opposite)
   );

   edge_filter u_second_edge (
      .clk_i      (CLK_I),
      .reset_i    (RESET_I),
      .run_i      (run),
      .sample_i   (capture_sample),
      .level_i    (second_sync[1]),
      .edge_sel_i (prescaler_edge_select.second_edge),
      .valid_o    (second_edge),
      .opposite_o ()
   );

   // a register in capture mode raises no match flag; clear-on-match still compares FIRST_COMPARE_I
   assign match_first  = count_tick && COUNT_O == FIRST_COMPARE_I
                         && !capture_compare_control.first_reg_capture_mode;
   assign match_second = count_tick && COUNT_O == SECOND_COMPARE_I
                         && !capture_compare_control.second_reg_capture_mode;

   always_ff @(posedge CLK_I) begin
      if (RESET_I || !run) begin
         COUNT_O <= timer_ctl_pkg::COUNT_ZERO;
      end else if (timer_mode_control.mode == timer_ctl_pkg::MODE_CLR_EDGE && first_edge) begin
         COUNT_O <= timer_ctl_pkg::COUNT_ZERO;
      end else if (count_tick) begin
         if (timer_mode_control.mode == timer_ctl_pkg::MODE_CLR_MATCH
             && COUNT_O == FIRST_COMPARE_I) begin
            COUNT_O <= timer_ctl_pkg::COUNT_ZERO;
         end else begin
            COUNT_O <= COUNT_O + timer_ctl_pkg::COUNT_ONE;
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         FIRST_MATCH_O  <= 1'b0;
         SECOND_MATCH_O <= 1'b0;
         OVERFLOW_O     <= 1'b0;
      end else begin
         FIRST_MATCH_O  <= match_first;
         SECOND_MATCH_O <= match_second;
         OVERFLOW_O     <= count_tick && COUNT_O == timer_ctl_pkg::COUNT_MAX;
      end
   end

   assign trig_first  = capture_compare_control.first_reg_capture_mode
                        && (capture_compare_control.first_reg_trigger_select
                            ? first_opposite : second_edge);
   assign trig_second = capture_compare_control.second_reg_capture_mode && first_edge;

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         FIRST_CAPTURE_O  <= timer_ctl_pkg::COUNT_ZERO;
         SECOND_CAPTURE_O <= timer_ctl_pkg::COUNT_ZERO;
      end else begin
         if (trig_first) begin
            FIRST_CAPTURE_O <= COUNT_O;
         end
         if (trig_second) begin
            SECOND_CAPTURE_O <= COUNT_O;
         end
      end
   end

   // one-shot is ended by the first compare match and is never enabled in clear-on-match mode
   assign oneshot_ok   = run && timer_output_control.oneshot_mode_enable
                         && timer_mode_control.mode != timer_ctl_pkg::MODE_CLR_MATCH;
   assign soft_trigger = (wr_toc && toc_wr.oneshot_soft_trigger)
                         || (timer_mode_control.mode == timer_ctl_pkg::MODE_CLR_EDGE
                             && first_edge);

   always_ff @(posedge CLK_I) begin
      if (RESET_I || !oneshot_ok) begin
         armed <= 1'b0;
      end else if (soft_trigger) begin
         armed <= 1'b1;
      end else if (match_first) begin
         armed <= 1'b0;
      end
   end

   assign flip = (match_first && timer_output_control.invert_on_first_match)
               ^ (match_second && timer_output_control.invert_on_second_match)
               ^ (first_edge && timer_mode_control.invert_on_edge);

   always_comb begin
      next_out_ff = out_ff;
      if (wr_toc && {toc_wr.output_level_set, toc_wr.output_level_reset}
                    == timer_ctl_pkg::LEVEL_SET) begin
         next_out_ff = 1'b1;
      end else if (wr_toc && {toc_wr.output_level_set, toc_wr.output_level_reset}
                             == timer_ctl_pkg::LEVEL_RESET) begin
         next_out_ff = 1'b0;
      end else if (oneshot_ok) begin
         if (armed && match_second) begin
            next_out_ff = 1'b1;
         end else if (armed && match_first) begin
            next_out_ff = 1'b0;
         end
      end else if (flip) begin
         next_out_ff = !out_ff;
      end
   end

   // the pin takes an enable written in the same cycle, so it never stays high once disabled
   assign next_enable = wr_toc ? toc_wr.output_enable_bit
                               : timer_output_control.output_enable_bit;

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         out_ff             <= 1'b0;
         TIMER_OUTPUT_PIN_O <= 1'b0;
      end else begin
         out_ff             <= next_out_ff;
         TIMER_OUTPUT_PIN_O <= next_enable && next_out_ff;
      end
   end

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RESET_I);

   property p_toc_read_zero;
      RD_I && ADDR_I == timer_ctl_pkg::ADDR_OUTPUT |=> RDATA_O[7:6] == 2'h0 && RDATA_O[3:2] == 2'h0;
   endproperty
   a_toc_read_zero: assert property (p_toc_read_zero)
      else $error("trigger or level bits read back nonzero");

   property p_pin_disabled;
      !timer_output_control.output_enable_bit |-> !TIMER_OUTPUT_PIN_O;
   endproperty
   a_pin_disabled: assert property (p_pin_disabled)
      else $error("timer output pin high while output disabled");

   property p_pin_follows;
      timer_output_control.output_enable_bit |-> TIMER_OUTPUT_PIN_O == out_ff;
   endproperty
   a_pin_follows: assert property (p_pin_follows)
      else $error("enabled pin does not follow the output flip-flop");

   property p_stop_clears;
      timer_mode_control.mode == timer_ctl_pkg::MODE_STOP |=> COUNT_O == timer_ctl_pkg::COUNT_ZERO;
   endproperty
   a_stop_clears: assert property (p_stop_clears)
      else $error("counter not cleared while stopped");

   property p_level_set;
      wr_toc && WDATA_I[3:2] == timer_ctl_pkg::LEVEL_SET |=> out_ff;
   endproperty
   a_level_set: assert property (p_level_set)
      else $error("level set write did not set the output flip-flop");

   property p_level_reset;
      wr_toc && WDATA_I[3:2] == timer_ctl_pkg::LEVEL_RESET |=> !out_ff;
   endproperty
   a_level_reset: assert property (p_level_reset)
      else $error("level reset write did not clear the output flip-flop");

   property p_invert_first;
      match_first && !match_second && !first_edge && !wr_toc && !oneshot_ok
      |=> out_ff == ($past(out_ff) ^ $past(timer_output_control.invert_on_first_match));
   endproperty
   a_invert_first: assert property (p_invert_first)
      else $error("first match inversion wrong");

   property p_invert_second;
      match_second && !match_first && !first_edge && !wr_toc && !oneshot_ok
      |=> out_ff == ($past(out_ff) ^ $past(timer_output_control.invert_on_second_match));
   endproperty
   a_invert_second: assert property (p_invert_second)
      else $error("second match inversion wrong");

   property p_capture_first;
      trig_first |=> FIRST_CAPTURE_O == $past(COUNT_O);
   endproperty
   a_capture_first: assert property (p_capture_first)
      else $error("first register did not capture the count");

   property p_capture_second;
      first_edge && capture_compare_control.second_reg_capture_mode
      |=> SECOND_CAPTURE_O == $past(COUNT_O);
   endproperty
   a_capture_second: assert property (p_capture_second)
      else $error("second register did not capture the count");

   property p_no_both_capture;
      capture_compare_control.first_reg_trigger_select
      && prescaler_edge_select.first_edge == timer_ctl_pkg::EDGE_BOTH |-> !trig_first;
   endproperty
   a_no_both_capture: assert property (p_no_both_capture)
      else $error("capture on opposite phase with both edges selected");

   property p_div4;
      run && prescaler_edge_select.clock_sel == timer_ctl_pkg::CLK_DIV4 && count_tick
      && !WR_I |=> !count_tick [*3];
   endproperty
   a_div4: assert property (p_div4)
      else $error("divide-by-4 count clock too fast");

   property p_oneshot_mode;
      timer_mode_control.mode == timer_ctl_pkg::MODE_CLR_MATCH |-> !armed;
   endproperty
   a_oneshot_mode: assert property (p_oneshot_mode)
      else $error("one-shot armed in clear-on-match mode");

endmodule : timer_capture_output_control

// >>> dv/timer_input_source.sv
// far-side source that drives both timer input pins
`timescale 1ns/1ps
module timer_input_source (
   input  wire logic       clk_i,
   input  wire logic [1:0] lvl_i,
   output logic            first_o,
   output logic            second_o
);
   // pins follow the request a cycle late; the bench holds each level many count clocks
   always_ff @(posedge clk_i) begin
      first_o  <= lvl_i[0];
      second_o <= lvl_i[1];
   end
endmodule : timer_input_source

// >>> dv/timer_capture_output_control_tb.sv
// self-checking bench of the timer capture and output control
`timescale 1ns/1ps
module timer_capture_output_control_tb;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [15:0] addr = 16'h0000;
   logic [7:0]  wdata = 8'h00;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [1:0]  lvl = 2'h0;
   logic [15:0] cmp = 16'h0000;
   logic [15:0] cmp2 = 16'h0000;
   logic        pa, pb, pin, m1, m2, ov;
   logic [7:0]  rdata, v, got;
   logic [15:0] cnt, fcap, scap, cap, prev;
   logic [31:0] seed = 32'd78296;
   logic [7:0]  lw [4] = '{8'h09, 8'h05, 8'h08, 8'h01};
   logic        le [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
   int          error_cnt = 0;
   int          n_compared = 0;
   int          r;
   timer_input_source u_timer_input_source (.clk_i(clk), .lvl_i(lvl), .first_o(pa),
      .second_o(pb));
   timer_capture_output_control u_timer_capture_output_control (.CLK_I(clk), .RESET_I(rst),
      .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .FIRST_TIMER_INPUT_I(pa),
      .SECOND_TIMER_INPUT_I(pb), .FIRST_COMPARE_I(cmp), .SECOND_COMPARE_I(cmp2),
      .RDATA_O(rdata), .TIMER_OUTPUT_PIN_O(pin), .COUNT_O(cnt), .FIRST_CAPTURE_O(fcap),
      .SECOND_CAPTURE_O(scap), .FIRST_MATCH_O(m1), .SECOND_MATCH_O(m2), .OVERFLOW_O(ov));
   always #5 clk = ~clk;
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs
   // readable bits of the prescaler, capture/compare and output control registers; trigger and level bits of output control read 0
   function automatic logic [7:0] rmask(input int k, input logic [7:0] d);
      return (k == 0) ? (d & 8'hF3) : (k == 1) ? (d & 8'h07) : (d & 8'h33);
   endfunction : rmask
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [15:0] a);
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      got = rdata;
   endtask : rd_reg
   task automatic wait_match(input int s);
      int k;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (((s == 1) ? m2 : m1) !== 1'b1 && k < 300);
      if (k >= 300) begin
         error_cnt++;
         report_and_stop();
      end
   endtask : wait_match
   initial begin
      repeat (8) @(negedge clk);
      rst = 1'b0;
      for (int i = 0; i < 4; i++) begin
         rd_reg(16'hFF61 + 16'(i));
         chk("reset or unmapped", 16'h0000, {8'h00, got});
      end
      for (int i = 0; i < 15; i++) begin
         seed = xs(seed);
         v = seed[7:0];
         r = i % 3;
         if (r == 2) begin
            v[6] = v[5];
            v[3] = v[3] & ~v[2];
         end else begin
            v[6] = v[6] | v[7];
            v[4] = v[4] | v[5];
         end
         wr_reg(16'hFF61 + 16'(r), v);
         rd_reg(16'hFF61 + 16'(r));
         chk("readback", {8'h00, rmask(r, v)}, {8'h00, got});
      end
      for (int i = 0; i < 4; i++) begin
         wr_reg(16'hFF63, lw[i]);
         chk("level pin", {15'h0000, le[i]}, {15'h0000, pin});
      end
      wr_reg(16'hFF61, 8'h00);
      wr_reg(16'hFF62, 8'h00);
      for (int i = 0; i < 2; i++) begin
         seed = xs(seed);
         cmp = {11'h000, seed[4:0]} + 16'h0008;
         // second match comes first, so each inversion is seen alone
         cmp2 = cmp - 16'h0003;
         wr_reg(16'hFF63, (i == 1) ? 8'h19 : 8'h0B);
         wr_reg(16'hFF60, 8'h04);
         wait_match(i);
         repeat (2) @(negedge clk);
         chk("pin after match", 16'h0000, {15'h0000, pin});
         wr_reg(16'hFF60, 8'h00);
         @(negedge clk);
         chk("count stopped", 16'h0000, cnt);
      end
      wr_reg(16'hFF62, 8'h01);
      wr_reg(16'hFF61, 8'h40);
      wr_reg(16'hFF60, 8'h04);
      repeat (5) @(negedge clk);
      lvl = 2'h2;
      cap = fcap;
      prev = cnt;
      // capture lands one cycle after the count it holds
      for (int k = 0; k < 40 && fcap === cap; k++) begin
         prev = cnt;
         @(negedge clk);
      end
      chk("capture value", prev, fcap);
      wr_reg(16'hFF60, 8'h00);
      lvl = 2'h0;
      wr_reg(16'hFF62, 8'h03);
      wr_reg(16'hFF61, 8'h30);
      wr_reg(16'hFF60, 8'h04);
      cap = fcap;
      repeat (10) @(negedge clk);
      lvl = 2'h1;
      repeat (20) @(negedge clk);
      lvl = 2'h0;
      repeat (20) @(negedge clk);
      chk("no capture", cap, fcap);
      wr_reg(16'hFF60, 8'h00);
      wr_reg(16'hFF62, 8'h04);
      wr_reg(16'hFF61, 8'h10);
      wr_reg(16'hFF60, 8'h04);
      repeat (5) @(negedge clk);
      lvl = 2'h1;
      cap = scap;
      prev = cnt;
      for (int k = 0; k < 40 && scap === cap; k++) begin
         prev = cnt;
         @(negedge clk);
      end
      chk("second capture", prev, scap);
      // at the full fxp rate the counter wraps within 65536 cycles of its start
      for (int k = 0; k < 66000 && ov !== 1'b1; k++) begin
         @(negedge clk);
      end
      chk("overflow", 16'h0001, {15'h0000, ov});
      chk("count wrap", 16'h0000, cnt);
      wr_reg(16'hFF60, 8'h00);
      wr_reg(16'hFF61, 8'h01);
      wr_reg(16'hFF60, 8'h04);
      // 42 fxp cycles at one count per 4 fxp cycles
      repeat (42) @(negedge clk);
      chk("div4 count", 16'h000A, cnt);
      wr_reg(16'hFF60, 8'h00);
      wr_reg(16'hFF62, 8'h00);
      wr_reg(16'hFF63, 8'h25);
      wr_reg(16'hFF60, 8'h04);
      wr_reg(16'hFF63, 8'h61);
      wait_match(1);
      chk("one-shot start", 16'h0001, {15'h0000, pin});
      wait_match(0);
      chk("one-shot end", 16'h0000, {15'h0000, pin});
      wr_reg(16'hFF60, 8'h00);
      wr_reg(16'hFF60, 8'h0C);
      wr_reg(16'hFF63, 8'h61);
      wait_match(1);
      chk("no one-shot on clear", 16'h0000, {15'h0000, pin});
      wait_match(0);
      chk("clear on match", 16'h0000, cnt);
      report_and_stop();
   end
endmodule : timer_capture_output_control_tb
